// >>> hdl/sosc_params.svh
`ifndef SOSC_PARAMS_SVH
`define SOSC_PARAMS_SVH

// ----------------------------------------
// Word layout
// ----------------------------------------
// One bit per output, bit 7 goes first on the wire
`define SOSC_WORD_W 8
// Smallest channel count the shifter can serve
`define SOSC_CH_MIN 2
// Entries of the command buffer
`define SOSC_BUF_DEPTH 2

// ----------------------------------------
// Timing
// ----------------------------------------
`define SOSC_CLK_NS 10
// Least low time of the reset pin the host must give
`define SOSC_RST_MIN_NS 250
`define SOSC_RST_MIN_CYC ((`SOSC_RST_MIN_NS + `SOSC_CLK_NS - 1) / `SOSC_CLK_NS)

`endif

// >>> hdl/sosc_pkg.sv
`default_nettype none
`include "sosc_params.svh"

package sosc_pkg;
  // Serial frame state
  typedef enum logic {
    SOSC_IDLE = 1'h0,
    SOSC_ACTIVE = 1'h1
  } sosc_frame_e;

  typedef logic [`SOSC_WORD_W-1:0] sosc_word_t;
endpackage

`default_nettype wire

// >>> hdl/sosc_stream_if.sv
`timescale 1ns/100ps
`default_nettype none

// Valid/ready word stream between the shifter, the buffer and the latches
interface sosc_stream_if #(
  parameter int W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );
  modport snk (
    input valid,
    input data,
    output ready
  );
endinterface

`default_nettype wire

// >>> hdl/sosc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
`include "sosc_params.svh"

module sosc_fifo #(
  parameter int W = `SOSC_WORD_W,
  parameter int DEPTH = `SOSC_BUF_DEPTH
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  sosc_stream_if.snk wr,
  sosc_stream_if.src rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sosc_fifo: DEPTH must be a power of two, at least 2");
  end

  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;

  // Honest flags; full stalls the shifter's pending word
  assign wr.ready = (cnt != (AW+1)'(DEPTH));
  assign rd.valid = (cnt != '0);
  assign rd.data = mem[rp];
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;

  // Next pointer and count
  always_comb
  begin
    next_wp = wp + AW'(push);
    next_rp = rp + AW'(pop);
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (rst | flush)
    begin
      next_wp = '0;
      next_rp = '0;
      next_cnt = '0;
    end
  end

  // Register pointers, write the slot
  always_ff @(posedge clk)
  begin
    wp <= next_wp;
    rp <= next_rp;
    cnt <= next_cnt;
    if (push)
      mem[wp] <= wr.data;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_FIFO_BOUND: assert property (cnt <= (AW+1)'(DEPTH))
    else $error("buffer count past depth");
  AST_FIFO_HOLD: assert property (rd.valid && !rd.ready && !flush |=> rd.valid && $stable(rd.data))
    else $error("buffered word lost under stall");
  AST_FIFO_FLUSH: assert property (flush |=> !rd.valid) // [RULE18]
    else $error("flush left a word in the buffer");
endmodule

`default_nettype wire

// >>> hdl/sosc_chan.sv
`timescale 1ns/100ps
`default_nettype none

module sosc_chan (
  input wire logic clk,
  input wire logic rst,
  input wire logic apply,
  input wire logic cmd_off,
  input wire logic strap_limit,
  input wire logic over_temp,
  input wire logic short_det,
  input wire logic open_load,
  input wire logic ov_global,
  output logic gate_on,
  output logic cur_limit,
  output logic status
);
  logic cmd_on, ot_lock, sc_lock;
  logic next_cmd_on, next_ot, next_sc, next_gate;

  // Latched command plus per-output fault locks
  always_comb
  begin
    // [RULE19] overheat locks off
    next_ot = ot_lock | over_temp;
    // [RULE7] short latches this output
    next_sc = sc_lock | (short_det & gate_on & ~strap_limit);
    next_cmd_on = cmd_on;
    if (apply)
    begin
      // [RULE12] low bit means on
      next_cmd_on = ~cmd_off;
      // [RULE21] restart only via write
      next_ot = over_temp;
      // A short still seen in the write cycle wins over the clear
      next_sc = short_det & gate_on & ~strap_limit;
    end
    // [RULE18] global overvoltage clears
    if (ov_global | rst)
    begin
      next_cmd_on = 1'h0;
      next_ot = 1'h0;
      next_sc = 1'h0;
    end
    // [RULE6] limit mode keeps gate
    next_gate = next_cmd_on & ~next_ot & ~next_sc & ~over_temp & ~ov_global & ~rst;
  end

  always_ff @(posedge clk)
  begin
    cmd_on <= next_cmd_on;
    ot_lock <= next_ot;
    sc_lock <= next_sc;
    gate_on <= next_gate;
  end

  // [RULE6] current limit flag
  assign cur_limit = gate_on & short_det & strap_limit;
  // [RULE17] four faults reach status
  // [RULE20] [RULE24] off high, on low
  assign status = (open_load & ~gate_on) ? 1'h0 : ((short_det & gate_on) ? 1'h1 : ~gate_on);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_OT_OFF: assert property (over_temp |=> !gate_on) // [RULE19]
    else $error("overheated output still on");
  AST_OT_HOLD: assert property (ot_lock && !apply |=> !gate_on) // [RULE21]
    else $error("output restarted without a write");
  AST_SHORT_LATCH: assert property ( // [RULE7]
    (short_det && gate_on && !strap_limit && !apply) ##1 !apply |=> !gate_on)
    else $error("short did not latch the output off");
  AST_LIMIT_ON: assert property ( // [RULE6]
    short_det && gate_on && strap_limit && !apply && !over_temp && !ov_global |=> gate_on)
    else $error("limit mode dropped the output");
  AST_CMD_ON: assert property ( // [RULE12]
    apply && !cmd_off && !over_temp && !ov_global && !(short_det && gate_on && !strap_limit)
    |=> gate_on)
    else $error("zero bit did not turn output on");
  AST_CMD_OFF: assert property (apply && cmd_off |=> !gate_on) // [RULE12]
    else $error("one bit did not turn output off");
  AST_STATUS_OFF: assert property ( // [RULE20]
    !gate_on && !open_load |-> status)
    else $error("off output not reported high");
endmodule

`default_nettype wire

// >>> hdl/sosc_core.sv
// Contract
// [RULE1] Reset clears shifter and latches, outputs off
// [RULE2] Host holds reset low at least 250 ns
// [RULE3] Undriven reset pin reads as asserted
// [RULE4] Host holds reset until supplies are good
// [RULE5] Host resets on low load supply
// [RULE6] Strap high: short stays on, current limited
// [RULE7] Strap low: short latches only that output
// [RULE8] Chip select fall enables output, loads status
// [RULE9] Chip select rise applies shifted command
// [RULE10] Serial output advances on clock rise
// [RULE11] Serial input sampled on clock fall
// [RULE12] Eight bits, zero on, one off
// [RULE13] Status shows result of previous command
// [RULE14] Host compares repeated status by XOR
// [RULE15] Host spaces checking writes over 100 us
// [RULE16] Host repeats word quickly for loopback
// [RULE17] Status shows four fault kinds
// [RULE18] Overvoltage global off, others per output
// [RULE19] Overheat turns off only that output
// [RULE20] Overheated output reports off when commanded on
// [RULE21] Recovery needs a new on command
// [RULE22] Select high: ignore clock, output high impedance
// [RULE23] Most significant bit first, output 7 first
// [RULE24] Status high off, low on when unfaulted
// [RULE25] Host keeps clock low at select edges
// [RULE26] Reset wins over any latch event
`timescale 1ns/100ps
`default_nettype none
`include "sosc_params.svh"

module sosc_core #(
  parameter int CH = `SOSC_WORD_W
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic short_latch_disable_strap,
  input wire logic load_supply_ov,
  input wire logic [CH-1:0] over_temp,
  input wire logic [CH-1:0] short_det,
  input wire logic [CH-1:0] open_load,
  output logic so,
  output logic so_oe,
  output logic reset_pulldown_en,
  output logic [CH-1:0] gate_on,
  output logic [CH-1:0] cur_limit
);
  localparam int SW = 3 * CH + 6;
  localparam logic [CH-1:0] ALL_OFF = {CH{1'h1}};
  localparam logic [CH-1:0] ALL_ZERO = {CH{1'h0}};

  if (CH < `SOSC_CH_MIN || CH > 32) begin : g_bad_ch
    $error("sosc_core: CH out of range");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic rose(input logic now, input logic was);
    return now & ~was;
  endfunction

  function automatic logic fell(input logic now, input logic was);
    return ~now & was;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [SW-1:0] pin_raw, pin_meta, pin_sync;
  logic rst_pin_s, cs_s, sclk_s, si_s, strap_s, ov_s;
  logic [CH-1:0] ot_s, sc_s, ol_s;

  assign pin_raw = {reset_pin_n, cs_n, sclk, si, short_latch_disable_strap,
                    load_supply_ov, over_temp, short_det, open_load};

  // Two stages; only the second is read by logic
  always_ff @(posedge clk)
  begin
    pin_meta <= pin_raw;
    pin_sync <= pin_meta;
  end

  assign {rst_pin_s, cs_s, sclk_s, si_s, strap_s, ov_s, ot_s, sc_s, ol_s} = pin_sync;

  // ----------------------------------------
  // Reset
  // ----------------------------------------
  logic chip_rst;

  // [RULE3] pad pull-down always on
  assign reset_pulldown_en = 1'h1;
  // [RULE26] reset overrides the frame
  assign chip_rst = rst | ~rst_pin_s;

  // ----------------------------------------
  // Frame shifter
  // ----------------------------------------
  sosc_pkg::sosc_frame_e state, next_state;
  logic [CH-1:0] shreg, next_shreg;
  logic [CH-1:0] pend_data, next_pend_data;
  logic [CH-1:0] status_vec;
  logic pend_valid, next_pend_valid;
  logic next_so, next_so_oe;
  logic cs_d, sclk_d;
  logic cs_fall, cs_rise, sclk_rise, sclk_fall;

  sosc_stream_if #(.W(CH)) wr_s ();
  sosc_stream_if #(.W(CH)) rd_s ();

  // Edges rely on the host keeping the clock low at select edges
  // [RULE25] clean select edges assumed
  assign cs_fall = fell(cs_s, cs_d);
  assign cs_rise = rose(cs_s, cs_d);
  assign sclk_rise = rose(sclk_s, sclk_d);
  assign sclk_fall = fell(sclk_s, sclk_d);

  // Next values of the frame logic
  always_comb
  begin
    next_state = state;
    next_shreg = shreg;
    next_so = so;
    next_pend_data = pend_data;
    // Pending word stays until the buffer takes it
    next_pend_valid = pend_valid & ~wr_s.ready;
    // [RULE22] driver off while deselected
    next_so_oe = ~cs_s;
    case (state)
      sosc_pkg::SOSC_IDLE:
      begin
        // [RULE8] status parallel load
        if (cs_fall)
        begin
          next_state = sosc_pkg::SOSC_ACTIVE;
          // [RULE13] status of last command
          next_shreg = status_vec;
          next_so = status_vec[CH-1];
        end
      end
      sosc_pkg::SOSC_ACTIVE:
      begin
        if (cs_rise)
        begin
          // [RULE9] hand word to latches
          next_state = sosc_pkg::SOSC_IDLE;
          next_pend_valid = 1'h1;
          next_pend_data = shreg;
        end
        else if (sclk_rise)
        begin
          // [RULE10] present next bit
          next_so = shreg[CH-1];
        end
        else if (sclk_fall)
        begin
          // [RULE11] sample on falling edge
          // [RULE23] shift toward the top bit
          next_shreg = {shreg[CH-2:0], si_s};
        end
      end
      default:
      begin
        next_state = sosc_pkg::SOSC_IDLE;
      end
    endcase
    // [RULE1] reset clears the shifter
    if (chip_rst)
    begin
      next_state = sosc_pkg::SOSC_IDLE;
      next_shreg = ALL_OFF;
      next_pend_valid = 1'h0;
    end
  end

  // Register the frame; serial output ignores the reset pin
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= sosc_pkg::SOSC_IDLE;
      shreg <= ALL_OFF;
      pend_valid <= 1'h0;
      pend_data <= ALL_OFF;
      so <= 1'h0;
      so_oe <= 1'h0;
      cs_d <= 1'h1;
      sclk_d <= 1'h0;
    end
    else
    begin
      state <= next_state;
      shreg <= next_shreg;
      pend_valid <= next_pend_valid;
      pend_data <= next_pend_data;
      so <= next_so;
      so_oe <= next_so_oe;
      cs_d <= cs_s;
      sclk_d <= sclk_s;
    end
  end

  // ----------------------------------------
  // Command buffer
  // ----------------------------------------
  logic apply;

  assign wr_s.valid = pend_valid;
  assign wr_s.data = pend_data;
  // Latches stall during overvoltage; the flush drops stale words
  assign rd_s.ready = ~ov_s;
  assign apply = rd_s.valid & rd_s.ready;

  sosc_fifo #(
    .W(CH),
    .DEPTH(`SOSC_BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst(chip_rst),
    .flush(ov_s),
    .wr(wr_s),
    .rd(rd_s)
  );

  // ----------------------------------------
  // Output channels
  // ----------------------------------------
  // Each output keeps its own faults; only overvoltage is shared
  for (genvar i = 0; i < CH; i++) begin : g_ch
    sosc_chan u_ch (
      .clk(clk),
      .rst(chip_rst),
      .apply(apply),
      .cmd_off(rd_s.data[i]),
      .strap_limit(strap_s),
      .over_temp(ot_s[i]),
      .short_det(sc_s[i]),
      .open_load(ol_s[i]),
      .ov_global(ov_s),
      .gate_on(gate_on[i]),
      .cur_limit(cur_limit[i]),
      .status(status_vec[i])
    );
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_cs_fall;
    state == sosc_pkg::SOSC_IDLE && cs_d && !cs_s && !chip_rst;
  endsequence

  sequence s_cs_rise;
    state == sosc_pkg::SOSC_ACTIVE && !cs_d && cs_s && !chip_rst;
  endsequence

  sequence s_clk_rise;
    state == sosc_pkg::SOSC_ACTIVE && !cs_s && !sclk_d && sclk_s && !chip_rst;
  endsequence

  sequence s_clk_fall;
    state == sosc_pkg::SOSC_ACTIVE && !cs_s && sclk_d && !sclk_s && !chip_rst;
  endsequence

  AST_CS_FALL_LOAD: assert property ( // [RULE8]
    s_cs_fall |=> shreg == $past(status_vec) && so == $past(status_vec[CH-1]) && so_oe)
    else $error("status not loaded at select fall");
  AST_CS_HIGH_HIZ: assert property (cs_s |=> !so_oe) // [RULE22]
    else $error("serial output driven while deselected");
  AST_IDLE_IGNORES: assert property ( // [RULE22]
    state == sosc_pkg::SOSC_IDLE && cs_s && !chip_rst |=> $stable(shreg))
    else $error("shifter moved while deselected");
  AST_CS_RISE_PUSH: assert property ( // [RULE9]
    s_cs_rise |=> pend_valid && pend_data == $past(shreg))
    else $error("word not handed on at select rise");
  AST_SO_ON_RISE: assert property ( // [RULE10]
    s_clk_rise |=> so == $past(shreg[CH-1]) && $stable(shreg))
    else $error("serial output not advanced on clock rise");
  AST_SI_ON_FALL: assert property ( // [RULE11]
    s_clk_fall |=> shreg[0] == $past(si_s) && shreg[CH-1:1] == $past(shreg[CH-2:0]))
    else $error("serial input not shifted on clock fall");
  AST_RST_CLEAR: assert property ( // [RULE1]
    chip_rst |=> shreg == ALL_OFF && gate_on == ALL_ZERO && !pend_valid)
    else $error("reset left state or outputs on");
  AST_RST_WINS: assert property ( // [RULE26]
    chip_rst && cs_rise |=> !pend_valid ##1 gate_on == ALL_ZERO)
    else $error("select rise beat reset");
  AST_OVP_OFF: assert property (ov_s |=> gate_on == ALL_ZERO) // [RULE18]
    else $error("overvoltage left an output on");
  // Driver follows select, whatever the frame state
  AST_OE_ON_SELECT: assert property (!cs_s |=> so_oe) // [RULE8]
    else $error("serial output not driven while selected");
endmodule

`default_nettype wire

// >>> tb/sosc_host.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Host side of the serial link
// ----------------------------------------
module sosc_host (
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe,
  output logic cs_n,
  output logic sclk,
  output logic si
);
  int acc = 0;

  // Pins idle: deselected, clock parked low
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // Data line is not held while deselected, so it keeps changing
  always @(posedge clk)
  begin
    if (cs_n)
      si <= ~si;
  end

  // Half period from a fractional count, 62.5 ns on average
  task automatic half();
    do
    begin
      @(posedge clk);
      acc += 20;
    end
    while (acc < 125);
    acc -= 125;
  endtask

  // One whole word each way
  task automatic xfer(input sosc_pkg::sosc_word_t tx, output sosc_pkg::sosc_word_t rx);
    @(posedge clk);
    cs_n <= 1'b0;
    @(posedge clk);
    for (int i = 7; i >= 0; i--)
    begin
      si <= tx[i];
      half();
      sclk <= 1'b1;
      half();
      // Only a driven line counts as data
      rx[i] = so_oe ? so : 1'bx;
      sclk <= 1'b0;
      @(posedge clk);
    end
    half();
    cs_n <= 1'b1;
  endtask

  // Clock pulses while deselected, which the device must ignore
  task automatic idle_clk(input int n);
    repeat (n)
    begin
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
    half();
  endtask
endmodule

`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_n = 1'b0;
  logic strap = 1'b0;
  logic ov = 1'b0;
  sosc_pkg::sosc_word_t over_temp = 8'h00;
  sosc_pkg::sosc_word_t short_det = 8'h00;
  sosc_pkg::sosc_word_t open_load = 8'h00;
  wire logic cs_n;
  wire logic sclk;
  wire logic si;
  wire logic so;
  wire logic so_oe;
  wire logic pd;
  wire logic [7:0] gate_on;
  wire logic [7:0] cur_limit;
  sosc_pkg::sosc_word_t rx;
  sosc_pkg::sosc_word_t cmd;
  sosc_pkg::sosc_word_t g;
  int err_count = 0;
  int tests_run = 0;

  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  initial
  begin
    forever #5 clk = ~clk;
  end

  sosc_core #(.CH(8)) dut_u (
    .clk(clk), .rst(rst), .reset_pin_n(reset_pin_n), .cs_n(cs_n), .sclk(sclk), .si(si),
    .short_latch_disable_strap(strap), .load_supply_ov(ov), .over_temp(over_temp),
    .short_det(short_det), .open_load(open_load), .so(so), .so_oe(so_oe),
    .reset_pulldown_en(pd), .gate_on(gate_on), .cur_limit(cur_limit)
  );

  sosc_host host_u (
    .clk(clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sclk(sclk), .si(si)
  );

  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  // Status: on reads short, off reads high unless open load pulls it low
  function automatic sosc_pkg::sosc_word_t st_exp(sosc_pkg::sosc_word_t gt,
    sosc_pkg::sosc_word_t sh, sosc_pkg::sosc_word_t ol);
    return (gt & sh) | (~gt & ~ol);
  endfunction

  task automatic chk_w(input sosc_pkg::sosc_word_t got, input sosc_pkg::sosc_word_t exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Frame, then room for the word to reach the gates
  task automatic send(input sosc_pkg::sosc_word_t c);
    host_u.xfer(c, rx);
    wt(12);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, far beyond the planned run
  initial
  begin
    wt(30000);
    err_count++;
    $display("watchdog expired");
    conclude();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'hf344));
    wt(16);
    rst <= 1'b0;
    // Pin stays low past 250 ns, as power-up asks
    // pin low 300 ns
    wt(14);
    reset_pin_n <= 1'b1;
    wt(6);
    chk_w(gate_on, 8'h00);
    chk_b(so_oe, 1'b0);
    chk_b(pd, 1'b1);
    $display("test reset done");
    // Random words with corner words first, open load on off outputs
    g = 8'h00;
    for (int n = 0; n < 24; n++)
    begin
      cmd = (n == 0) ? 8'h00 : (n == 1) ? 8'hff : sosc_pkg::sosc_word_t'($urandom);
      open_load <= sosc_pkg::sosc_word_t'($urandom) & ~g;
      wt(4);
      send(cmd);
      chk_w(rx, st_exp(g, 8'h00, open_load));
      g = ~cmd;
      chk_w(gate_on, g);
    end
    open_load <= 8'h00;
    $display("test random words done");
    // Overheat on one output, relock while hot, new write to recover
    send(8'h00);
    over_temp <= 8'h10;
    wt(8);
    chk_w(gate_on, 8'hef);
    send(8'h00);
    chk_w(rx, 8'h10);
    over_temp <= 8'h00;
    wt(8);
    chk_w(gate_on, 8'hef);
    send(8'h00);
    chk_w(gate_on, 8'hff);
    $display("test overheat done");
    // Short with strap low latches one output only
    short_det <= 8'h01;
    wt(8);
    chk_w(gate_on, 8'hfe);
    chk_w(cur_limit, 8'h00);
    short_det <= 8'h00;
    send(8'h00);
    chk_w(rx, 8'h01);
    chk_w(gate_on, 8'hff);
    // Short with strap high stays on, limited
    strap <= 1'b1;
    short_det <= 8'h80;
    wt(8);
    chk_w(gate_on, 8'hff);
    chk_w(cur_limit, 8'h80);
    send(8'h00);
    chk_w(rx, st_exp(8'hff, 8'h80, 8'h00));
    short_det <= 8'h00;
    strap <= 1'b0;
    $display("test short done");
    // Overvoltage turns everything off until rewritten
    ov <= 1'b1;
    wt(8);
    chk_w(gate_on, 8'h00);
    ov <= 1'b0;
    wt(8);
    chk_w(gate_on, 8'h00);
    send(8'h00);
    chk_w(rx, 8'hff);
    chk_w(gate_on, 8'hff);
    $display("test overvoltage done");
    // Reset pin between frames, as on a load supply dip
    // reset on supply dip
    reset_pin_n <= 1'b0;
    wt(26);
    reset_pin_n <= 1'b1;
    wt(6);
    chk_w(gate_on, 8'h00);
    send(8'h5a);
    chk_w(rx, 8'hff);
    chk_w(gate_on, 8'ha5);
    // Data line keeps toggling and the clock pulses while deselected
    wt(60);
    host_u.idle_clk(4);
    wt(8);
    chk_w(gate_on, 8'ha5);
    chk_b(so_oe, 1'b0);
    $display("test reset pin done");
    send(8'h5a);
    chk_w(rx, 8'h5a);
    // Reset pin low across a select rise drops the word
    fork
      host_u.xfer(8'h00, rx);
      begin
        wt(40);
        reset_pin_n <= 1'b0;
        wt(100);
        reset_pin_n <= 1'b1;
      end
    join
    wt(12);
    chk_w(gate_on, 8'h00);
    $display("test reset in frame done");
    // second write over 100 us later
    cmd = sosc_pkg::sosc_word_t'($urandom);
    send(cmd);
    chk_w(rx, 8'hff);
    wt(10001);
    send(cmd);
    chk_w(rx ^ cmd, 8'h00);
    chk_w(gate_on, ~cmd);
    $display("test repeat check done");
    conclude();
  end
endmodule

`default_nettype wire
